// ---- logic/gpe_pkg.sv ----
// package for the four-line general purpose port: offsets, resets, carriers
// assumes a 32-bit APB master; the port bits sit in the low lanes
//
// Behaviour
// - four lines, each with direction and latch
// - direction one turns driver off, pin floats
// - direction zero drives pin from latch bit
// - line 3 input only, direction reads one
// - pin read gives pins; write loads latch
// - set and clear writes are read-modify-write of sampled pins
// - master clear enabled: line 3 reads zero
// - analog select forces digital reads to zero
// - analog select leaves digital output untouched
// - direction still gates drivers on analog lines
// - pin priority: LCD, then CCP, then latch
// - input functions stay active while outputting
// - analog select bits reset to one
// - upper unimplemented bits read zero, writes ignored
package gpe_pkg;

  localparam int GPE_LINES = 4;
  localparam int GPE_MUX_LINES = 3;
  localparam int GPE_ADDR_W = 8;

  localparam logic [7:0] GPE_OFF_PIN = 8'h00;
  localparam logic [7:0] GPE_OFF_LAT = 8'h04;
  localparam logic [7:0] GPE_OFF_DIR = 8'h08;
  localparam logic [7:0] GPE_OFF_ANSEL = 8'h0C;
  localparam logic [7:0] GPE_OFF_CFG = 8'h10;
  localparam logic [7:0] GPE_OFF_SET = 8'h14;
  localparam logic [7:0] GPE_OFF_CLR = 8'h18;

  localparam int GPE_CFG_MASTER_CLEAR_PIN_ENABLE_BIT = 0;
  localparam int GPE_LINE3 = 3;

  localparam logic [3:0] GPE_LAT_RST = 4'h0;
  localparam logic [2:0] GPE_DIR_RST = 3'h7;
  localparam logic [2:0] GPE_ANSEL_RST = 3'h7;
  localparam logic GPE_MASTER_CLEAR_PIN_ENABLE_RST = 1'b1;

  // on-chip functions that may claim lines 0..2
  typedef struct packed {
    logic [2:0] lcd_en;
    logic [2:0] lcd_data;
    logic [2:0] ccp_en;
    logic [2:0] ccp_data;
  } gpe_periph_t;

  // pad drive towards the pins
  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } gpe_pad_t;

endpackage : gpe_pkg

// ---- logic/gpe_port.sv ----
// four-line general purpose port with APB register access
// assumes pins arrive asynchronously; peripheral outputs are on clk_sys
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module gpe_port #(
  parameter int ADDR_W = gpe_pkg::GPE_ADDR_W
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] pin_in,
  output gpe_pkg::gpe_pad_t pads,
  input wire gpe_pkg::gpe_periph_t periph,
  output logic [3:0] line_digital_in,
  output logic master_clear_pin_enable
);

  ////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input logic [7:0] off);
    reg_hit = (a == ADDR_W'(off));
  endfunction : reg_hit

  function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
    reg_mapped = reg_hit(a, gpe_pkg::GPE_OFF_PIN) ||
                 reg_hit(a, gpe_pkg::GPE_OFF_LAT) ||
                 reg_hit(a, gpe_pkg::GPE_OFF_DIR) ||
                 reg_hit(a, gpe_pkg::GPE_OFF_ANSEL) ||
                 reg_hit(a, gpe_pkg::GPE_OFF_CFG) ||
                 reg_hit(a, gpe_pkg::GPE_OFF_SET) ||
                 reg_hit(a, gpe_pkg::GPE_OFF_CLR);
  endfunction : reg_mapped

  ////////////////////////////////////////////////////////////////////////
  // state

  logic [3:0] lat_reg;
  logic [3:0] lat_next;
  logic [2:0] dir_reg;
  logic [2:0] dir_next;
  logic [2:0] ansel_reg;
  logic [2:0] ansel_next;
  logic master_clear_pin_enable_reg;
  logic master_clear_pin_enable_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic [3:0] pad_out_reg;
  logic [3:0] pad_out_next;
  logic [3:0] pad_oe_reg;
  logic [3:0] pad_oe_next;
  logic [3:0] din_reg;
  logic [3:0] din_next;

  logic [3:0] pin_sync;
  logic [3:0] pin_value;
  logic [3:0] dir_eff;
  logic setup_phase;
  logic access_phase;
  logic wr_en;

  ////////////////////////////////////////////////////////////////////////
  // pin sampling

  gpe_sync #(
    .WIDTH(gpe_pkg::GPE_LINES)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .async_in(pin_in),
    .sync_out(pin_sync)
  );

  assign dir_eff = {1'b1, dir_reg};

  // digital view of the pins, masked for analog and master clear
  always_comb begin
    pin_value = pin_sync;
    pin_value[2:0] = pin_sync[2:0] & ~ansel_reg;
    if (master_clear_pin_enable_reg) begin
      pin_value[gpe_pkg::GPE_LINE3] = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, read data captured in the setup cycle

  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;
  assign wr_en = access_phase && pwrite && pstrb[0] && reg_mapped(paddr);
  assign pready = 1'b1;
  assign pslverr = access_phase && !reg_mapped(paddr);

  always_comb begin
    lat_next = lat_reg;
    dir_next = dir_reg;
    ansel_next = ansel_reg;
    master_clear_pin_enable_next = master_clear_pin_enable_reg;
    prdata_next = prdata_reg;
    // register writes on the access edge
    if (wr_en) begin
      if (reg_hit(paddr, gpe_pkg::GPE_OFF_PIN)) begin
        lat_next = pwdata[3:0];
      end else if (reg_hit(paddr, gpe_pkg::GPE_OFF_LAT)) begin
        lat_next = pwdata[3:0];
      end else if (reg_hit(paddr, gpe_pkg::GPE_OFF_DIR)) begin
        dir_next = pwdata[2:0];
      end else if (reg_hit(paddr, gpe_pkg::GPE_OFF_ANSEL)) begin
        ansel_next = pwdata[2:0];
      end else if (reg_hit(paddr, gpe_pkg::GPE_OFF_CFG)) begin
        master_clear_pin_enable_next = pwdata[gpe_pkg::GPE_CFG_MASTER_CLEAR_PIN_ENABLE_BIT];
      end else if (reg_hit(paddr, gpe_pkg::GPE_OFF_SET)) begin
        lat_next = pin_value | pwdata[3:0];
      end else if (reg_hit(paddr, gpe_pkg::GPE_OFF_CLR)) begin
        lat_next = pin_value & ~pwdata[3:0];
      end
    end
    if (setup_phase && !pwrite) begin
      prdata_next = 32'h0000_0000;
      if (reg_hit(paddr, gpe_pkg::GPE_OFF_PIN)) begin
        prdata_next[3:0] = pin_value;
      end else if (reg_hit(paddr, gpe_pkg::GPE_OFF_LAT)) begin
        prdata_next[3:0] = lat_reg;
      end else if (reg_hit(paddr, gpe_pkg::GPE_OFF_DIR)) begin
        prdata_next[3:0] = dir_eff;
      end else if (reg_hit(paddr, gpe_pkg::GPE_OFF_ANSEL)) begin
        prdata_next[2:0] = ansel_reg;
      end else if (reg_hit(paddr, gpe_pkg::GPE_OFF_CFG)) begin
        prdata_next[gpe_pkg::GPE_CFG_MASTER_CLEAR_PIN_ENABLE_BIT] = master_clear_pin_enable_reg;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lat_reg <= gpe_pkg::GPE_LAT_RST;
      dir_reg <= gpe_pkg::GPE_DIR_RST;
      ansel_reg <= gpe_pkg::GPE_ANSEL_RST;
      master_clear_pin_enable_reg <= gpe_pkg::GPE_MASTER_CLEAR_PIN_ENABLE_RST;
      prdata_reg <= 32'h0000_0000;
    end else begin
      lat_reg <= lat_next;
      dir_reg <= dir_next;
      ansel_reg <= ansel_next;
      master_clear_pin_enable_reg <= master_clear_pin_enable_next;
      prdata_reg <= prdata_next;
    end
  end

  assign prdata = prdata_reg;
  assign master_clear_pin_enable = master_clear_pin_enable_reg;

  ////////////////////////////////////////////////////////////////////////
  // pad drive and output priority

  logic [2:0] line_src;

  generate
    for (genvar i = 0; i < gpe_pkg::GPE_MUX_LINES; i++) begin : g_mux
      assign line_src[i] = periph.lcd_en[i] ? periph.lcd_data[i] :
                           periph.ccp_en[i] ? periph.ccp_data[i] :
                           lat_reg[i];
    end
  endgenerate

  always_comb begin
    // driven value; analog select not used
    pad_out_next = {1'b0, line_src};
    // direction gates driver; also on analog lines
    pad_oe_next = ~dir_eff;
    // digital inputs stay visible while driving
    din_next = pin_value;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pad_out_reg <= 4'h0;
      pad_oe_reg <= 4'h0;
      din_reg <= 4'h0;
    end else begin
      pad_out_reg <= pad_out_next;
      pad_oe_reg <= pad_oe_next;
      din_reg <= din_next;
    end
  end

  assign pads.out = pad_out_reg;
  assign pads.oe = pad_oe_reg;
  assign line_digital_in = din_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_set_write;
    setup_phase && pwrite && pstrb[0] &&
      reg_hit(paddr, gpe_pkg::GPE_OFF_SET) ##1 access_phase;
  endsequence

  sequence s_pin_write;
    setup_phase && pwrite && pstrb[0] &&
      reg_hit(paddr, gpe_pkg::GPE_OFF_PIN) ##1 access_phase;
  endsequence

  property p_dir_float;
    @(posedge clk_sys) disable iff (rst)
      dir_reg[1] |=> !pads.oe[1];
  endproperty
  a_dir_float: assert property (p_dir_float)
    else $error("line 1 driven while set as input");

  property p_drive_latch;
    @(posedge clk_sys) disable iff (rst)
      (!dir_reg[0] && !periph.lcd_en[0] && !periph.ccp_en[0])
        |=> pads.oe[0] && (pads.out[0] == $past(lat_reg[0]));
  endproperty
  a_drive_latch: assert property (p_drive_latch)
    else $error("line 0 does not drive latch value");

  property p_line3_input;
    @(posedge clk_sys) disable iff (rst)
      setup_phase && !pwrite && reg_hit(paddr, gpe_pkg::GPE_OFF_DIR)
        |=> prdata[3] && !pads.oe[3] && !pads.out[3];
  endproperty
  a_line3_input: assert property (p_line3_input)
    else $error("line 3 direction not fixed as input");

  property p_pin_write;
    @(posedge clk_sys) disable iff (rst)
      s_pin_write |=> lat_reg == $past(pwdata[3:0]);
  endproperty
  a_pin_write: assert property (p_pin_write)
    else $error("pin register write missed the latch");

  property p_set_rmw;
    @(posedge clk_sys) disable iff (rst)
      s_set_write |=> lat_reg == ($past(pin_value) | $past(pwdata[3:0]));
  endproperty
  a_set_rmw: assert property (p_set_rmw)
    else $error("set write not based on sampled pins");

  property p_mclr_read;
    @(posedge clk_sys) disable iff (rst)
      master_clear_pin_enable_reg && setup_phase && !pwrite &&
        reg_hit(paddr, gpe_pkg::GPE_OFF_PIN) |=> !prdata[3];
  endproperty
  a_mclr_read: assert property (p_mclr_read)
    else $error("line 3 read nonzero under master clear");

  property p_analog_zero;
    @(posedge clk_sys) disable iff (rst)
      ansel_reg[2] ##1 ansel_reg[2] |=> !line_digital_in[2];
  endproperty
  a_analog_zero: assert property (p_analog_zero)
    else $error("analog line read nonzero");

  property p_lcd_priority;
    @(posedge clk_sys) disable iff (rst)
      periph.lcd_en[1] |=> pads.out[1] == $past(periph.lcd_data[1]);
  endproperty
  a_lcd_priority: assert property (p_lcd_priority)
    else $error("LCD segment lost pin priority");

  property p_upper_zero;
    @(posedge clk_sys) disable iff (rst)
      access_phase |-> prdata[31:4] == 28'h0000000;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("unimplemented bits read nonzero");

  property p_reset_values;
    @(posedge clk_sys)
      rst |=> dir_reg == gpe_pkg::GPE_DIR_RST &&
        ansel_reg == gpe_pkg::GPE_ANSEL_RST &&
        lat_reg == gpe_pkg::GPE_LAT_RST;
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("reset values wrong");

endmodule : gpe_port

`default_nettype wire

// ---- logic/gpe_sync.sv ----
// two-flop synchroniser for asynchronous pin levels
// assumes the inputs may change at any time relative to clk_sys
`timescale 1ns/1ps
`default_nettype none

module gpe_sync #(
  parameter int WIDTH = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  // first stage is read only by the second
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_out = stage2_reg;

endmodule : gpe_sync

`default_nettype wire

// ---- sim/gpe_pad_model.sv ----
// pin-side model: outside drivers and released lines of the port
// assumes pads arrive registered from the port on clk_sys
`timescale 1ns/1ps
`default_nettype none

module gpe_pad_model (
  input wire logic clk_sys,
  input wire gpe_pkg::gpe_pad_t pads,
  input wire logic [3:0] ext_val,
  input wire logic [3:0] ext_en,
  output logic [3:0] pin_in
);
  logic [3:0] float_reg;

  // an undriven line wanders, so a stale level never reads as valid
  initial float_reg = 4'h5;
  always @(posedge clk_sys) float_reg <= ~float_reg;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_in[i] = pads.oe[i] ? pads.out[i] :
        (ext_en[i] ? ext_val[i] : float_reg[i]);
    end
  end
endmodule : gpe_pad_model

`default_nettype wire

// ---- sim/tb.sv ----
// self-checking bench for the four-line port, model compared over APB
// assumes gpe_pad_model resolves pins from pads and outside drive
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic clk_sys, rst, psel, penable, pwrite, pslverr, pready, mce, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, pin_in, ldi, ext, m_lat, p;
  logic [2:0] m_dir, m_ans;
  logic m_mc;
  logic [15:0] rnd;
  gpe_pkg::gpe_pad_t pads;
  gpe_pkg::gpe_periph_t periph;
  int err_total, n_compared;

  gpe_port u_gpe_port (.clk_sys(clk_sys), .rst(rst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pads(pads), .periph(periph),
    .line_digital_in(ldi), .master_clear_pin_enable(mce));
  gpe_pad_model u_gpe_pad_model (.clk_sys(clk_sys), .pads(pads),
    .ext_val(ext), .ext_en(4'hF), .pin_in(pin_in));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {1'b0, v[15:1]} ^ (v[0] ? 16'hB400 : 16'h0000);
  endfunction : lfsr

  // expected peripheral-over-latch selection per line
  function automatic logic [2:0] mux();
    for (int i = 0; i < 3; i++) begin
      mux[i] = periph.lcd_en[i] ? periph.lcd_data[i] :
        (periph.ccp_en[i] ? periph.ccp_data[i] : m_lat[i]);
    end
  endfunction : mux

  function automatic logic [3:0] view();
    logic [3:0] l;
    l = {ext[3], (mux() & ~m_dir) | (ext[2:0] & m_dir)};
    return l & ~{m_mc, m_ans};
  endfunction : view

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic wr_en, input logic [7:0] a,
    input logic [31:0] d, input logic [3:0] s);
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(rd, exp);
  endtask : rdc

  task automatic reset_chk();
    rst <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    m_lat = 4'h0;
    m_dir = 3'h7;
    m_ans = 3'h7;
    m_mc = 1'b1;
    @(posedge clk_sys);
    chk({28'h0, pads.oe}, 32'h0);
    rdc(gpe_pkg::GPE_OFF_DIR, 32'h0000000F);
    rdc(gpe_pkg::GPE_OFF_ANSEL, 32'h00000007);
    rdc(gpe_pkg::GPE_OFF_LAT, 32'h0);
    rdc(gpe_pkg::GPE_OFF_CFG, 32'h1);
  endtask : reset_chk

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (5000) @(posedge clk_sys);
    err_total++;
    final_report();
  end

  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    rst = 1'b1;
    periph = '0;
    ext = 4'h0;
    rnd = 16'hF425;
    err_total = 0;
    n_compared = 0;
    @(posedge clk_sys);
    reset_chk();
    wr(gpe_pkg::GPE_OFF_DIR, 32'hFFFFFFF0);
    m_dir = 3'h0;
    rdc(gpe_pkg::GPE_OFF_DIR, 32'h00000008);
    for (int k = 0; k < 24; k++) begin
      rnd = lfsr(rnd);
      ext <= rnd[3:0];
      periph <= rnd[15:4];
      rnd = lfsr(rnd);
      wr(k[0] ? gpe_pkg::GPE_OFF_PIN : gpe_pkg::GPE_OFF_LAT, {2{rnd}});
      m_lat = rnd[3:0];
      wr(gpe_pkg::GPE_OFF_DIR, {20'h00000, rnd[15:4]});
      m_dir = rnd[6:4];
      wr(gpe_pkg::GPE_OFF_ANSEL, {rnd, 7'h00, rnd[15:7]});
      m_ans = rnd[9:7];
      wr(gpe_pkg::GPE_OFF_CFG, {rnd[15:0], rnd[14:0], rnd[10]});
      m_mc = rnd[10];
      repeat (4) @(posedge clk_sys);
      chk({28'h0, pads.out}, {29'h0, mux()});
      chk({28'h0, pads.oe}, {29'h0, ~m_dir});
      chk({31'h0, mce}, {31'h0, m_mc});
      rdc(gpe_pkg::GPE_OFF_PIN, {28'h0, view()});
      chk({28'h0, ldi}, {28'h0, view()});
      p = view();
      rnd = lfsr(rnd);
      wr(k[0] ? gpe_pkg::GPE_OFF_SET : gpe_pkg::GPE_OFF_CLR, {2{rnd}});
      m_lat = k[0] ? (p | rnd[3:0]) : (p & ~rnd[3:0]);
      rdc(gpe_pkg::GPE_OFF_LAT, {28'h0, m_lat});
    end
    apb(1'b1, gpe_pkg::GPE_OFF_LAT, ~{28'h0, m_lat}, 4'h0);
    rdc(gpe_pkg::GPE_OFF_LAT, {28'h0, m_lat});
    apb(1'b1, 8'h1C, 32'hFFFFFFFF, 4'hF);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, 8'h80, 32'h0, 4'h0);
    chk(rd, 32'h0);
    chk({31'h0, er}, 32'h1);
    reset_chk();
    // analog select cleared before digital reads
    ext <= 4'hA;
    wr(gpe_pkg::GPE_OFF_ANSEL, 32'h0);
    m_ans = 3'h0;
    wr(gpe_pkg::GPE_OFF_CFG, 32'h0);
    m_mc = 1'b0;
    repeat (4) @(posedge clk_sys);
    rdc(gpe_pkg::GPE_OFF_PIN, {28'h0, view()});
    chk({28'h0, ldi}, {28'h0, view()});
    final_report();
  end
endmodule : tb

`default_nettype wire
